// *** rtl/nsrp_pkg.sv ***
// Shared constants and types for the network slot ROM pager
package nsrp_pkg;
   localparam int          NSRP_DATA_W      = 16;
   localparam int          NSRP_ROM_W       = 8;
   localparam int          NSRP_OFS_W       = 12;
   localparam int          NSRP_PAGE_W      = 8;
   localparam int          NSRP_ROM_ADDR_W  = NSRP_OFS_W + NSRP_PAGE_W;
   localparam int          NSRP_CLK_MHZ     = 200;
   localparam int          NSRP_IRQ_CLR_NS  = 250;
   // Longest time: round down
   localparam int          NSRP_IRQ_CLR_CYC = (NSRP_IRQ_CLR_NS * NSRP_CLK_MHZ)
                                              / 1000;
   localparam int          NSRP_STRB_NS     = 180;
   localparam int          NSRP_STRB_CYC    = (NSRP_STRB_NS * NSRP_CLK_MHZ
                                               + 999) / 1000;
   localparam int          NSRP_GAP_NS      = 250;
   localparam int          NSRP_GAP_CYC     = (NSRP_GAP_NS * NSRP_CLK_MHZ
                                               + 999) / 1000;
   localparam logic [NSRP_OFS_W-1:0] NSRP_OFS_RST = 12'h000;
   localparam logic [NSRP_OFS_W-1:0] NSRP_OFS_ONE = 12'h001;
   localparam logic [7:0]  NSRP_CNT_ONE     = 8'h01;
   localparam logic [7:0]  NSRP_CNT_ZERO    = 8'h00;
   // Host decode windows (I/O byte addresses)
   localparam logic [31:0] NSRP_ROM_LO      = 32'h0302_B000;
   localparam logic [31:0] NSRP_ROM_HI      = 32'h0302_B3FF;
   localparam logic [31:0] NSRP_NET_LO      = 32'h0302_B800;
   localparam logic [31:0] NSRP_NET_HI      = 32'h0302_BBFF;
   localparam int          NSRP_PAGE_LSB    = 2;
   typedef enum logic [2:0] {
      NSRP_H_IDLE, NSRP_H_SETUP, NSRP_H_STROBE, NSRP_H_HOLD, NSRP_H_GAP
   } nsrp_host_st_t;
endpackage : nsrp_pkg

// *** rtl/nsrp_if.sv ***
// Slot bus between host motherboard and network card
`timescale 1ns/1ps
interface nsrp_if;
   import nsrp_pkg::*;
   logic                   ior_n;
   logic                   iow_n;
   logic                   csnet_n;
   logic                   romsel_n;
   logic                   bus_rst;
   logic [NSRP_PAGE_W-1:0] latched_page_addr;
   logic [NSRP_DATA_W-1:0] host_data;
   logic                   host_data_oe;
   logic [NSRP_DATA_W-1:0] card_data;
   logic                   card_data_oe;
   logic                   irq;
   logic                   ready_oe;
   // Resolved wires
   logic [NSRP_DATA_W-1:0] slot_data_bus;
   logic                   ready;
   assign slot_data_bus = card_data_oe ? card_data :
                          (host_data_oe ? host_data : '1);
   assign ready = ~ready_oe;
   modport host (output ior_n, iow_n, csnet_n, romsel_n, bus_rst,
                 latched_page_addr, host_data, host_data_oe,
                 input slot_data_bus, ready, irq);
   modport card (input ior_n, iow_n, csnet_n, romsel_n, bus_rst,
                 latched_page_addr, slot_data_bus,
                 output card_data, card_data_oe, irq, ready_oe);
endinterface : nsrp_if

// *** rtl/nsrp_card.sv ***
// Card end: paged boot ROM counter, data drive, interrupt and ready
`timescale 1ns/1ps
module nsrp_card
   import nsrp_pkg::*;
(
   // Clock and reset
   input  wire logic                       i_core_clk,
   input  wire logic                       i_rst_n,
   // Slot side
   nsrp_if.card                            bus,
   // ROM array
   output logic [NSRP_ROM_ADDR_W-1:0]      o_rom_addr,
   input  wire logic [NSRP_ROM_W-1:0]      i_rom_data,
   // Network controller side
   output logic                            o_net_rd,
   output logic                            o_net_wr,
   output logic [NSRP_DATA_W-1:0]          o_net_wdata,
   input  wire logic [NSRP_DATA_W-1:0]     i_net_rdata,
   input  wire logic                       i_net_irq,
   input  wire logic                       i_net_busy
);
   // Two-flop synchronisers for all slot inputs
   logic [4:0] ctl_s1_reg, ctl_s2_reg, ctl_s1_next, ctl_s2_next;
   logic [NSRP_PAGE_W-1:0] pg_s1_reg, pg_s2_reg, pg_s1_next, pg_s2_next;
   logic [NSRP_DATA_W-1:0] dt_s1_reg, dt_s2_reg, dt_s1_next, dt_s2_next;
   logic [1:0] nx_s1_reg, nx_s2_reg, nx_s1_next, nx_s2_next;
   logic ior_d_reg, ior_d_next, iow_d_reg, iow_d_next;
   logic [NSRP_OFS_W-1:0] ofs_reg, ofs_next;
   logic [NSRP_DATA_W-1:0] dout_reg, dout_next;
   logic oe_reg, oe_next, irq_reg, irq_next, rdy_reg, rdy_next;
   logic nrd_reg, nrd_next, nwr_reg, nwr_next;
   logic [NSRP_DATA_W-1:0] nwd_reg, nwd_next;
   logic [NSRP_ROM_ADDR_W-1:0] ra_reg, ra_next;
   logic ior_n, iow_n, cs_n, rom_n, brst, nirq, nbusy;
   logic rd_rise, wr_fall;
   logic rom_rd_act, net_rd_act, net_acc_act;

   // True while a select and its strobe are both low
   function automatic logic sel_strobe(input logic sel_n,
                                       input logic strb_n);
      sel_strobe = ~sel_n & ~strb_n;
   endfunction : sel_strobe

   assign ior_n = ctl_s2_reg[0];
   assign iow_n = ctl_s2_reg[1];
   assign cs_n  = ctl_s2_reg[2];
   assign rom_n = ctl_s2_reg[3];
   assign brst  = ctl_s2_reg[4];
   assign nirq  = nx_s2_reg[0];
   assign nbusy = nx_s2_reg[1];
   assign rd_rise = ior_n & ~ior_d_reg;
   assign wr_fall = ~iow_n & iow_d_reg;
   // Every decode sees the selects through the same two stages
   assign rom_rd_act  = sel_strobe(rom_n, ior_n);
   assign net_rd_act  = sel_strobe(cs_n, ior_n);
   assign net_acc_act = net_rd_act | sel_strobe(cs_n, iow_n);

   always_comb begin
      ctl_s1_next = {bus.bus_rst, bus.romsel_n, bus.csnet_n,
                     bus.iow_n, bus.ior_n};
      ctl_s2_next = ctl_s1_reg;
      pg_s1_next  = bus.latched_page_addr;
      pg_s2_next  = pg_s1_reg;
      dt_s1_next  = bus.slot_data_bus;
      dt_s2_next  = dt_s1_reg;
      nx_s1_next  = {i_net_busy, i_net_irq};
      nx_s2_next  = nx_s1_reg;
      ior_d_next  = ior_n;
      iow_d_next  = iow_n;
   end

   // Offset counter: a clear outranks a same-cycle advance
   always_comb begin
      ofs_next = ofs_reg;
      if (brst | sel_strobe(rom_n, iow_n)) begin
         ofs_next = NSRP_OFS_RST;
      end else if (~rom_n & rd_rise) begin
         // Natural 12-bit wrap gives 4096-byte pages
         ofs_next = ofs_reg + NSRP_OFS_ONE;
      end
      // The ROM sees the offset one cycle late; reads stay stable anyway
      ra_next = {pg_s2_reg, ofs_reg};
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         ofs_reg <= NSRP_OFS_RST;
         ra_reg  <= '0;
      end else begin
         ofs_reg <= ofs_next;
         ra_reg  <= ra_next;
      end
   end

   // Read data and its drive enable switch in the same cycle
   always_comb begin
      dout_next = dout_reg;
      oe_next   = rom_rd_act | net_rd_act;
      if (rom_rd_act) begin
         dout_next = {{(NSRP_DATA_W-NSRP_ROM_W){1'b0}},
                      i_rom_data};
      end else if (net_rd_act) begin
         dout_next = i_net_rdata;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         dout_reg <= '0;
         oe_reg   <= 1'b0;
      end else begin
         dout_reg <= dout_next;
         oe_reg   <= oe_next;
      end
   end

   // Status toward the host
   always_comb begin
      // Follows the controller level, so a clear drops it in 3 cycles
      irq_next = nirq;
      // Stretch only net accesses while the controller is busy
      rdy_next = net_acc_act & nbusy;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         irq_reg <= 1'b0;
         rdy_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
         rdy_reg <= rdy_next;
      end
   end

   // Controller strobes: one pulse at the start of each access
   always_comb begin
      nrd_next = 1'b0;
      nwr_next = 1'b0;
      nwd_next = nwd_reg;
      if (net_rd_act & ior_d_reg) begin
         nrd_next = 1'b1;
      end
      if (~cs_n & wr_fall) begin
         nwr_next = 1'b1;
         // Data passed the same two stages as the strobe
         nwd_next = dt_s2_reg;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         nrd_reg <= 1'b0;
         nwr_reg <= 1'b0;
         nwd_reg <= '0;
      end else begin
         nrd_reg <= nrd_next;
         nwr_reg <= nwr_next;
         nwd_reg <= nwd_next;
      end
   end

   // Synchronisers run free; nothing reads the first stage but the second
   always_ff @(posedge i_core_clk) begin
      ctl_s1_reg <= ctl_s1_next;
      ctl_s2_reg <= ctl_s2_next;
      pg_s1_reg  <= pg_s1_next;
      pg_s2_reg  <= pg_s2_next;
      dt_s1_reg  <= dt_s1_next;
      dt_s2_reg  <= dt_s2_next;
      nx_s1_reg  <= nx_s1_next;
      nx_s2_reg  <= nx_s2_next;
   end

   // Edge detectors reset to the idle level, so no false edge follows
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         ior_d_reg <= 1'b1;
         iow_d_reg <= 1'b1;
      end else begin
         ior_d_reg <= ior_d_next;
         iow_d_reg <= iow_d_next;
      end
   end

   assign bus.card_data    = dout_reg;
   assign bus.card_data_oe = oe_reg;
   assign bus.irq          = irq_reg;
   assign bus.ready_oe     = rdy_reg;
   assign o_rom_addr       = ra_reg;
   assign o_net_rd         = nrd_reg;
   assign o_net_wr         = nwr_reg;
   assign o_net_wdata      = nwd_reg;
endmodule : nsrp_card

// *** rtl/nsrp_host.sv ***
// Host end: address decode and strobe sequencing toward the card
`timescale 1ns/1ps
module nsrp_host
   import nsrp_pkg::*;
(
   // Clock and reset
   input  wire logic                   i_core_clk,
   input  wire logic                   i_rst_n,
   // Request port
   input  wire logic                   i_req,
   input  wire logic                   i_we,
   input  wire logic [31:0]            i_addr,
   input  wire logic [NSRP_DATA_W-1:0] i_wdata,
   output logic                        o_busy,
   output logic                        o_done,
   output logic [NSRP_DATA_W-1:0]      o_rdata,
   output logic                        o_irq,
   output logic                        o_miss,
   // Slot side
   nsrp_if.host                        bus
);
   nsrp_host_st_t st_reg, st_next;
   logic [7:0] cnt_reg, cnt_next;
   logic we_reg, we_next, rom_reg, rom_next, net_reg, net_next;
   logic [NSRP_PAGE_W-1:0] pg_reg, pg_next;
   logic [NSRP_DATA_W-1:0] wd_reg, wd_next, rd_reg, rd_next;
   logic done_reg, done_next, miss_reg, miss_next;
   logic rdy_s1_reg, rdy_s2_reg, irq_s1_reg, irq_s2_reg;
   logic [NSRP_DATA_W-1:0] d_s1_reg, d_s2_reg;
   logic hit_rom, hit_net;

   function automatic logic in_win(input logic [31:0] a,
                                   input logic [31:0] lo,
                                   input logic [31:0] hi);
      in_win = (a >= lo) && (a <= hi);
   endfunction : in_win

   assign hit_rom = in_win(i_addr, NSRP_ROM_LO, NSRP_ROM_HI);
   assign hit_net = in_win(i_addr, NSRP_NET_LO, NSRP_NET_HI);

   always_comb begin
      st_next = st_reg;
      cnt_next = (cnt_reg == NSRP_CNT_ZERO) ? cnt_reg : cnt_reg - NSRP_CNT_ONE;
      we_next = we_reg;
      rom_next = rom_reg;
      net_next = net_reg;
      pg_next = pg_reg;
      wd_next = wd_reg;
      rd_next = rd_reg;
      done_next = 1'b0;
      miss_next = 1'b0;
      case (st_reg)
         NSRP_H_IDLE: begin
            if (i_req & (hit_rom | hit_net)) begin
               st_next = NSRP_H_SETUP;
               we_next = i_we;
               rom_next = hit_rom;
               net_next = hit_net;
               pg_next = i_addr[NSRP_PAGE_LSB +: NSRP_PAGE_W];
               wd_next = i_wdata;
               cnt_next = NSRP_CNT_ONE;
            end else if (i_req) begin
               miss_next = 1'b1;
            end
         end
         NSRP_H_SETUP: begin
            if (cnt_reg == NSRP_CNT_ZERO) begin
               st_next = NSRP_H_STROBE;
               cnt_next = 8'(NSRP_STRB_CYC);
            end
         end
         NSRP_H_STROBE: begin
            // Hold while the card pulls ready low
            if ((cnt_reg == NSRP_CNT_ZERO) & rdy_s2_reg) begin
               st_next = NSRP_H_HOLD;
               rd_next = d_s2_reg;
            end
         end
         NSRP_H_HOLD: begin
            st_next = NSRP_H_GAP;
            cnt_next = 8'(NSRP_GAP_CYC);
            done_next = 1'b1;
         end
         NSRP_H_GAP: begin
            if (cnt_reg == NSRP_CNT_ZERO) begin
               st_next = NSRP_H_IDLE;
               rom_next = 1'b0;
               net_next = 1'b0;
            end
         end
         default: st_next = NSRP_H_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      rdy_s1_reg <= bus.ready;
      rdy_s2_reg <= rdy_s1_reg;
      irq_s1_reg <= bus.irq;
      irq_s2_reg <= irq_s1_reg;
      d_s1_reg <= bus.slot_data_bus;
      d_s2_reg <= d_s1_reg;
      if (!i_rst_n) begin
         st_reg <= NSRP_H_IDLE;
         cnt_reg <= NSRP_CNT_ZERO;
         we_reg <= 1'b0;
         rom_reg <= 1'b0;
         net_reg <= 1'b0;
         pg_reg <= '0;
         wd_reg <= '0;
         rd_reg <= '0;
         done_reg <= 1'b0;
         miss_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         we_reg <= we_next;
         rom_reg <= rom_next;
         net_reg <= net_next;
         pg_reg <= pg_next;
         wd_reg <= wd_next;
         rd_reg <= rd_next;
         done_reg <= done_next;
         miss_reg <= miss_next;
      end
   end

   // Strobes are registered state decodes; all active low
   logic strb_reg;
   logic strb_next;
   always_comb begin
      strb_next = (st_next == NSRP_H_STROBE);
   end
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         strb_reg <= 1'b0;
      end else begin
         strb_reg <= strb_next;
      end
   end
   assign bus.ior_n = ~(strb_reg & ~we_reg);
   assign bus.iow_n = ~(strb_reg & we_reg);
   assign bus.romsel_n = ~rom_reg;
   assign bus.csnet_n = ~net_reg;
   assign bus.bus_rst = ~i_rst_n;
   assign bus.latched_page_addr = pg_reg;
   assign bus.host_data = wd_reg;
   assign bus.host_data_oe = we_reg & (rom_reg | net_reg);
   assign o_busy = rom_reg | net_reg;
   assign o_done = done_reg;
   assign o_rdata = rd_reg;
   assign o_irq = irq_s2_reg;
   assign o_miss = miss_reg;
endmodule : nsrp_host

// *** verification/nsrp_assertions.sv ***
// Slot bus protocol checks between host and card ends
`timescale 1ns/1ps
module nsrp_assertions
   import nsrp_pkg::*;
(
   // Clock and reset
   input  wire logic                   i_core_clk,
   input  wire logic                   i_rst_n,
   // Slot signals
   input  wire logic                   ior_n,
   input  wire logic                   iow_n,
   input  wire logic                   csnet_n,
   input  wire logic                   romsel_n,
   input  wire logic [NSRP_DATA_W-1:0] card_data,
   input  wire logic                   card_data_oe,
   input  wire logic                   ready_oe
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // Stretched strobes stay far below 255 cycles in this bench
   logic [7:0]                         low_cnt_reg;
   logic [7:0]                         low_cnt_next;
   always_comb begin
      low_cnt_next = ior_n ? NSRP_CNT_ZERO : low_cnt_reg + NSRP_CNT_ONE;
   end
   always_ff @(posedge i_core_clk) begin
      low_cnt_reg <= i_rst_n ? low_cnt_next : NSRP_CNT_ZERO;
   end
   property p_drive_read;
      card_data_oe |-> !$past(ior_n, 3) &&
                       !($past(romsel_n, 3) && $past(csnet_n, 3));
   endproperty
   a_drive_read: assert property (p_drive_read)
      else $error("card drives data outside a read");
   property p_upper_zero;
      card_data_oe && !romsel_n |->
         card_data[NSRP_DATA_W-1:NSRP_ROM_W] == '0;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("ROM byte not on low lanes");
   property p_no_write_drive;
      !iow_n |-> !card_data_oe;
   endproperty
   a_no_write_drive: assert property (p_no_write_drive)
      else $error("card drives data during a write");
   property p_one_select;
      romsel_n || csnet_n;
   endproperty
   a_one_select: assert property (p_one_select)
      else $error("both selects low");
   property p_strobe_sel;
      $fell(ior_n) || $fell(iow_n) |-> !romsel_n || !csnet_n;
   endproperty
   a_strobe_sel: assert property (p_strobe_sel)
      else $error("strobe without a select");
   property p_ready_net;
      ready_oe |-> romsel_n;
   endproperty
   a_ready_net: assert property (p_ready_net)
      else $error("ready pulled during a ROM cycle");
   property p_stretch_hold;
      ready_oe && $past(ready_oe) && $past(ready_oe, 2) &&
      $past(ready_oe, 3) |-> !$rose(ior_n) && !$rose(iow_n);
   endproperty
   a_stretch_hold: assert property (p_stretch_hold)
      else $error("strobe released while ready low");
   property p_strobe_len;
      $rose(ior_n) |-> low_cnt_reg >= NSRP_STRB_CYC;
   endproperty
   a_strobe_len: assert property (p_strobe_len)
      else $error("read strobe too short");
   c_rom_read: cover property (card_data_oe && !romsel_n);
   c_stretch: cover property (ready_oe && !ior_n);
   c_rom_write: cover property (!iow_n && !romsel_n);
endmodule : nsrp_assertions

// *** verification/network_slot_rom_pager_bench.sv ***
// Self-checking bench joining host and card ends of the slot bus
`timescale 1ns/1ps
module network_slot_rom_pager_bench
   import nsrp_pkg::*;
;
   logic                       i_core_clk = 1'b0;
   logic                       i_rst_n = 1'b0;
   logic                       req = 1'b0;
   logic                       we = 1'b0;
   logic [31:0]                addr = 32'h0000_0000;
   logic [NSRP_DATA_W-1:0]     wdata = 16'h0000;
   logic [NSRP_DATA_W-1:0]     net_rdata = 16'h0000;
   logic                       net_irq = 1'b0;
   logic                       net_busy = 1'b0;
   logic                       busy, done, host_irq, miss, net_rd, net_wr;
   logic [NSRP_DATA_W-1:0]     rdata, net_wdata, last_wdata;
   logic [NSRP_ROM_ADDR_W-1:0] rom_addr;
   logic [NSRP_ROM_W-1:0]      rom_data;
   int                         miscompares = 0;
   int                         samples_checked = 0;
   int                         rd_pulses = 0;
   int                         wr_pulses = 0;
   int                         cycles;
   always #2.5 i_core_clk = ~i_core_clk;
   function automatic logic [7:0] rom_f(input logic [19:0] a);
      return a[7:0] ^ a[19:12] ^ {a[11:8], a[11:8]};
   endfunction : rom_f
   assign rom_data = rom_f(rom_addr);
   nsrp_if i_nsrp_if ();
   nsrp_host i_nsrp_host (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
      .i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wdata),
      .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_irq(host_irq),
      .o_miss(miss), .bus(i_nsrp_if.host));
   nsrp_card i_nsrp_card (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
      .bus(i_nsrp_if.card), .o_rom_addr(rom_addr), .i_rom_data(rom_data),
      .o_net_rd(net_rd), .o_net_wr(net_wr), .o_net_wdata(net_wdata),
      .i_net_rdata(net_rdata), .i_net_irq(net_irq), .i_net_busy(net_busy));
   nsrp_assertions i_nsrp_assertions (.i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n), .ior_n(i_nsrp_if.ior_n), .iow_n(i_nsrp_if.iow_n),
      .csnet_n(i_nsrp_if.csnet_n), .romsel_n(i_nsrp_if.romsel_n),
      .card_data(i_nsrp_if.card_data),
      .card_data_oe(i_nsrp_if.card_data_oe),
      .ready_oe(i_nsrp_if.ready_oe));
   always @(posedge i_core_clk) begin
      if (net_rd === 1'b1) rd_pulses++;
      if (net_wr === 1'b1) begin
         wr_pulses++;
         last_wdata = net_wdata;
      end
   end
   task automatic test_done();
      $display("checked %0d, mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   task automatic check_data(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
      end
   endtask : check_data
   task automatic check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
      end
   endtask : check_bit
   // Holds address and data until the next call, past the strobe end
   task automatic access(input logic w, input logic [31:0] a,
                         input logic [15:0] d, output logic [15:0] q,
                         output logic m);
      int n;
      req <= 1'b1;
      we <= w;
      addr <= a;
      wdata <= d;
      @(posedge i_core_clk);
      req <= 1'b0;
      n = 0;
      while (done !== 1'b1 && miss !== 1'b1 && n < 400) begin
         @(posedge i_core_clk);
         n++;
      end
      q = rdata;
      m = miss;
      cycles = n;
      while (busy !== 1'b0 && n < 400) begin
         @(posedge i_core_clk);
         n++;
      end
      if (n >= 400) check_bit(1'b0, 1'b1);
   endtask : access
   task automatic rom_read(input logic [7:0] pg, input logic [11:0] ofs);
      logic [15:0] q;
      logic        m;
      access(1'b0, NSRP_ROM_LO | {22'h00_0000, pg, 2'b00}, 16'h0000, q, m);
      check_data(q, {8'h00, rom_f({pg, ofs})});
   endtask : rom_read
   task automatic do_reset();
      i_rst_n <= 1'b0;
      repeat (16) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      @(posedge i_core_clk);
   endtask : do_reset
   initial begin
      logic [15:0] q;
      logic        m;
      do_reset();
      for (int k = 0; k < 3; k++) rom_read(8'h05, 12'(k));
      rom_read(8'hFF, 12'h003);
      $display("test rom_sequence done");
      access(1'b1, NSRP_ROM_LO, 16'h1234, q, m);
      rom_read(8'h00, 12'h000);
      rom_read(8'h00, 12'h001);
      $display("test rom_clear done");
      net_rdata <= 16'hC3A5;
      net_busy <= 1'b1;
      fork
         begin
            repeat (60) @(posedge i_core_clk);
            net_busy <= 1'b0;
         end
         access(1'b0, NSRP_NET_LO + 32'h0000_0010, 16'h0000, q, m);
      join
      check_bit(cycles > 60, 1'b1);
      check_data(q, 16'hC3A5);
      check_data(16'(rd_pulses), 16'h0001);
      access(1'b1, NSRP_NET_HI - 32'h0000_0003, 16'h5AF0, q, m);
      check_data(16'(wr_pulses), 16'h0001);
      check_data(last_wdata, 16'h5AF0);
      net_busy <= 1'b1;
      fork
         begin
            repeat (60) @(posedge i_core_clk);
            net_busy <= 1'b0;
         end
         access(1'b1, NSRP_NET_LO, 16'h0F0F, q, m);
      join
      check_bit(cycles > 60, 1'b1);
      check_data(16'(wr_pulses), 16'h0002);
      check_data(last_wdata, 16'h0F0F);
      rom_read(8'h00, 12'h002);
      $display("test net_access done");
      access(1'b0, 32'h0302_B400, 16'h0000, q, m);
      check_bit(m, 1'b1);
      check_data(16'(rd_pulses), 16'h0001);
      rom_read(8'h00, 12'h003);
      $display("test miss done");
      net_irq <= 1'b1;
      repeat (20) @(posedge i_core_clk);
      check_bit(i_nsrp_if.irq, 1'b1);
      check_bit(host_irq, 1'b1);
      net_irq <= 1'b0;
      repeat (NSRP_IRQ_CLR_CYC) @(posedge i_core_clk);
      check_bit(i_nsrp_if.irq, 1'b0);
      check_bit(host_irq, 1'b0);
      $display("test irq done");
      do_reset();
      rom_read(8'h05, 12'h000);
      $display("test reset_clear done");
      test_done();
   end
   initial begin
      repeat (20000) @(posedge i_core_clk);
      miscompares++;
      $display("unexpected at %0t: watchdog expired", $time);
      test_done();
   end
endmodule : network_slot_rom_pager_bench
